// ==== core/clamp_pkg.sv ====
package clamp_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int CODE_W = 13;
    localparam int ANGLE_W = 16;
    localparam int SW_W = 10;
    localparam int RANGE_W = 6;
    localparam int PCT_W = 7;

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_LOW_LIMIT = 4'ha;
    localparam logic [ADDR_W-1:0] OFS_HIGH_LIMIT = 4'hb;
    localparam logic [ADDR_W-1:0] OFS_SWITCH_RANGE = 4'he;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_CTRL = 4'hf;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h1;
    localparam logic [ADDR_W-1:0] OFS_OUTPUT_CODE = 4'h2;

    // field positions
    localparam int CODE_MSB = 12;
    localparam int SW_MSB = 15;
    localparam int SW_LSB = 6;
    localparam int RANGE_MSB = 5;
    localparam int SLOPE_BIT = 8;
    localparam int ST_SWITCHED = 0;
    localparam int ST_AT_LOW = 1;
    localparam int ST_AT_HIGH = 2;
    localparam int ST_LOW_RESERVED = 3;
    localparam int ST_HIGH_RESERVED = 4;
    localparam int ST_LIMITS_CROSSED = 5;
    localparam int ST_FALLING = 6;

    // reset values
    localparam logic [DATA_W-1:0] RST_LOW_LIMIT = 16'h0100;
    localparam logic [DATA_W-1:0] RST_HIGH_LIMIT = 16'h12ff;
    localparam logic [DATA_W-1:0] RST_SWITCH_RANGE = 16'hffc1;
    localparam logic RST_SLOPE = 1'b0;

    // dac code scale
    localparam logic [CODE_W-1:0] CODE_FULL = 13'h1400;
    localparam logic [CODE_W-1:0] CODE_MIN = 13'h0100;
    localparam logic [CODE_W-1:0] CODE_MAX = 13'h1300;
    localparam int CODES_PER_STEP = 256;
    localparam int PCT_PER_STEP = 5;
endpackage : clamp_pkg

// ==== core/clamp_limiter.sv ====
`timescale 1ns/1ps
module clamp_limiter
    import clamp_pkg::*;
(
    input wire logic [CODE_W-1:0] raw_code, // unclamped code from the angle path
    input wire logic [CODE_W-1:0] low_limit, // lower clamp code
    input wire logic [CODE_W-1:0] high_limit, // upper clamp code
    input wire logic [ANGLE_W-1:0] angle, // field angle, full scale 180 degrees
    input wire logic [SW_W-1:0] switch_angle, // clamp switch angle
    input wire logic falling, // inverted characteristic selected
    output logic [CODE_W-1:0] code, // limited code
    output logic switched, // switch-angle condition holds
    output logic at_low, // held at lower clamp
    output logic at_high // held at upper clamp
);
    logic [CODE_W-1:0] shaped;

    always_comb begin
        // inverted output mirrors around full supply; saturate instead of wrapping
        if (falling) begin
            shaped = (raw_code > CODE_FULL) ? '0 : CODE_FULL - raw_code;
        end else begin
            shaped = raw_code;
        end
        // switch angle is compared on the same 180-degree scale, low bits padded
        switched = angle > {switch_angle, {(ANGLE_W-SW_W){1'b0}}};
        at_low = 1'b0;
        at_high = 1'b0;
        if (switched && !falling) begin
            code = low_limit;
            at_low = 1'b1;
        end else if (switched && falling) begin
            code = high_limit;
            at_high = 1'b1;
        end else if (shaped < low_limit) begin
            code = low_limit;
            at_low = 1'b1;
        end else if (shaped > high_limit) begin
            code = high_limit;
            at_high = 1'b1;
        end else begin
            code = shaped;
        end
    end
endmodule : clamp_limiter

// ==== core/angle_output_clamp_config.sv ====
`timescale 1ns/1ps
module angle_output_clamp_config
    import clamp_pkg::*;
(
    input wire logic MCLK, // 10 MHz system clock
    input wire logic RST_N, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] ADDR, // register address
    input wire logic [DATA_W-1:0] WDATA, // register write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    output logic [DATA_W-1:0] RDATA, // read data, cycle after RD
    input wire logic [ANGLE_W-1:0] ANGLE, // measured field angle
    input wire logic [CODE_W-1:0] RAW_CODE, // unclamped output code
    output logic [CODE_W-1:0] DAC_CODE, // clamped output dac code
    output logic SWITCH_ACTIVE, // switch-angle condition in force
    output logic SLOPE_FALLING, // inverted characteristic selected
    output logic [RANGE_W-1:0] RANGE_SCALE_HIGH, // range scale factor high bits
    output logic [PCT_W-1:0] SUPPLY_PCT // output level in percent of supply
);
    logic [CODE_W-1:0] output_low_limit;
    logic [CODE_W-1:0] output_high_limit;
    logic [SW_W-1:0] switch_angle;
    logic [RANGE_W-1:0] range_scale_high_bits;
    logic slope_falling;
    logic [CODE_W-1:0] next_output_low_limit;
    logic [CODE_W-1:0] next_output_high_limit;
    logic [SW_W-1:0] next_switch_angle;
    logic [RANGE_W-1:0] next_range_scale_high_bits;
    logic next_slope_falling;

    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] next_rdata;

    logic [CODE_W-1:0] dac_code;
    logic switch_active;
    logic at_low;
    logic at_high;
    logic [PCT_W-1:0] supply_pct;
    logic [CODE_W-1:0] next_dac_code;
    logic next_switch_active;
    logic next_at_low;
    logic next_at_high;
    logic [PCT_W-1:0] next_supply_pct;

    logic [CODE_W-1:0] lim_code;
    logic lim_switched;
    logic lim_at_low;
    logic lim_at_high;
    logic low_reserved;
    logic high_reserved;
    logic limits_crossed;
    logic [DATA_W-1:0] status_word;

    // percent of supply from a dac code, truncated toward zero
    // 16 bits hold any 13-bit code times five; the 7-bit result wraps only above code 6553
    function automatic logic [PCT_W-1:0] code_to_pct(input logic [CODE_W-1:0] c);
        logic [CODE_W+3-1:0] scaled;
        scaled = {3'b000, c} * (CODE_W+3)'(PCT_PER_STEP);
        return PCT_W'(scaled / (CODE_W+3)'(CODES_PER_STEP));
    endfunction : code_to_pct

    // configuration registers
    // a write lands at its strobe edge, so a read in the next cycle already sees it
    always_comb begin
        next_output_low_limit = output_low_limit;
        next_output_high_limit = output_high_limit;
        next_switch_angle = switch_angle;
        next_range_scale_high_bits = range_scale_high_bits;
        next_slope_falling = slope_falling;
        if (WR) begin
            case (ADDR)
                OFS_LOW_LIMIT: begin
                    // bits above the code are not stored
                    next_output_low_limit = WDATA[CODE_MSB:0];
                end
                OFS_HIGH_LIMIT: begin
                    next_output_high_limit = WDATA[CODE_MSB:0];
                end
                OFS_SWITCH_RANGE: begin
                    // stored as written; nothing here recomputes it from the limits
                    next_switch_angle = WDATA[SW_MSB:SW_LSB];
                    next_range_scale_high_bits = WDATA[RANGE_MSB:0];
                end
                OFS_OUTPUT_CTRL: begin
                    next_slope_falling = WDATA[SLOPE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            output_low_limit <= RST_LOW_LIMIT[CODE_MSB:0];
            output_high_limit <= RST_HIGH_LIMIT[CODE_MSB:0];
            switch_angle <= RST_SWITCH_RANGE[SW_MSB:SW_LSB];
            range_scale_high_bits <= RST_SWITCH_RANGE[RANGE_MSB:0];
            slope_falling <= RST_SLOPE;
        end else begin
            output_low_limit <= next_output_low_limit;
            output_high_limit <= next_output_high_limit;
            switch_angle <= next_switch_angle;
            range_scale_high_bits <= next_range_scale_high_bits;
            slope_falling <= next_slope_falling;
        end
    end

    // reserved limit codes are not blocked, only reported, so a bad load stays visible
    always_comb begin
        low_reserved = output_low_limit < CODE_MIN;
        high_reserved = output_high_limit > CODE_MAX;
        limits_crossed = output_low_limit > output_high_limit;
        status_word = '0;
        status_word[ST_SWITCHED] = switch_active;
        status_word[ST_AT_LOW] = at_low;
        status_word[ST_AT_HIGH] = at_high;
        status_word[ST_LOW_RESERVED] = low_reserved;
        status_word[ST_HIGH_RESERVED] = high_reserved;
        status_word[ST_LIMITS_CROSSED] = limits_crossed;
        status_word[ST_FALLING] = slope_falling;
    end

    // read port; unmapped addresses read zero
    // idle cycles return zero, so a stale word never lingers on the bus
    always_comb begin
        next_rdata = '0;
        if (RD) begin
            case (ADDR)
                OFS_LOW_LIMIT: begin
                    next_rdata = {{(DATA_W-CODE_W){1'b0}}, output_low_limit};
                end
                OFS_HIGH_LIMIT: begin
                    next_rdata = {{(DATA_W-CODE_W){1'b0}}, output_high_limit};
                end
                OFS_SWITCH_RANGE: begin
                    next_rdata = {switch_angle, range_scale_high_bits};
                end
                OFS_OUTPUT_CTRL: begin
                    next_rdata[SLOPE_BIT] = slope_falling;
                end
                OFS_STATUS: begin
                    next_rdata = status_word;
                end
                OFS_OUTPUT_CODE: begin
                    next_rdata = {{(DATA_W-CODE_W){1'b0}}, dac_code};
                end
                default: begin
                    next_rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            rdata <= '0;
        end else begin
            rdata <= next_rdata;
        end
    end

    clamp_limiter u_limiter (
        .raw_code(RAW_CODE),
        .low_limit(output_low_limit),
        .high_limit(output_high_limit),
        .angle(ANGLE),
        .switch_angle(switch_angle),
        .falling(slope_falling),
        .code(lim_code),
        .switched(lim_switched),
        .at_low(lim_at_low),
        .at_high(lim_at_high)
    );

    // output path, one register stage after the inputs
    // the limiter is combinational, so this stage is the whole output latency
    always_comb begin
        next_dac_code = lim_code;
        next_switch_active = lim_switched;
        next_at_low = lim_at_low;
        next_at_high = lim_at_high;
        next_supply_pct = code_to_pct(lim_code);
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            // park at the lower clamp reset code until the first sample
            dac_code <= RST_LOW_LIMIT[CODE_MSB:0];
            switch_active <= 1'b0;
            at_low <= 1'b0;
            at_high <= 1'b0;
            // percent view tracks the parked code, so both outputs agree from reset on
            supply_pct <= code_to_pct(RST_LOW_LIMIT[CODE_MSB:0]);
        end else begin
            dac_code <= next_dac_code;
            switch_active <= next_switch_active;
            at_low <= next_at_low;
            at_high <= next_at_high;
            supply_pct <= next_supply_pct;
        end
    end

    assign RDATA = rdata;
    assign DAC_CODE = dac_code;
    assign SWITCH_ACTIVE = switch_active;
    assign SLOPE_FALLING = slope_falling;
    assign RANGE_SCALE_HIGH = range_scale_high_bits;
    assign SUPPLY_PCT = supply_pct;
endmodule : angle_output_clamp_config

// ==== tb/clamp_cfg_asserts.sv ====
`timescale 1ns/1ps
module clamp_cfg_asserts
    import clamp_pkg::*;
(
    input wire logic MCLK, // clock
    input wire logic RST_N, // sync reset, active low
    input wire logic [ADDR_W-1:0] ADDR, // address
    input wire logic [DATA_W-1:0] WDATA, // write data
    input wire logic WR, // write strobe
    input wire logic RD, // read strobe
    input wire logic [DATA_W-1:0] RDATA, // read data
    input wire logic [ANGLE_W-1:0] ANGLE, // field angle
    input wire logic [CODE_W-1:0] RAW_CODE, // unclamped code
    input wire logic [CODE_W-1:0] DAC_CODE, // clamped code
    input wire logic SWITCH_ACTIVE, // switch condition
    input wire logic SLOPE_FALLING, // slope view
    input wire logic [RANGE_W-1:0] RANGE_SCALE_HIGH, // range bits
    input wire logic [PCT_W-1:0] SUPPLY_PCT // percent of supply
);
    logic [CODE_W-1:0] lo;
    logic [CODE_W-1:0] hi;
    logic [DATA_W-1:0] sw;
    logic [SW_W-1:0] sw_ang;
    logic slp;
    assign sw_ang = sw[SW_MSB:SW_LSB];
    // mirror of the writable words, so outputs can be tied to what software wrote
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            lo <= RST_LOW_LIMIT[CODE_MSB:0];
            hi <= RST_HIGH_LIMIT[CODE_MSB:0];
            sw <= RST_SWITCH_RANGE;
            slp <= RST_SLOPE;
        end else if (WR) begin
            if (ADDR == OFS_LOW_LIMIT) lo <= WDATA[CODE_MSB:0];
            if (ADDR == OFS_HIGH_LIMIT) hi <= WDATA[CODE_MSB:0];
            if (ADDR == OFS_SWITCH_RANGE) sw <= WDATA;
            if (ADDR == OFS_OUTPUT_CTRL) slp <= WDATA[SLOPE_BIT];
        end
    end
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    a_read_back: assert property ($past(RD) && $past(ADDR) == OFS_LOW_LIMIT
        |-> RDATA == {3'h0, $past(lo)}) else $error("low limit read back wrong");
    a_pct_scale: assert property (
        SUPPLY_PCT == PCT_W'((20'(DAC_CODE) * 20'd5) >> 8)) else $error("percent wrong");
    a_switch_cmp: assert property ($past(RST_N) |->
        SWITCH_ACTIVE == ($past(ANGLE) > {$past(sw_ang), 6'h0})) else $error("switch wrong");
    a_low_forced: assert property ($past(RST_N) && SWITCH_ACTIVE && !$past(slp)
        |-> DAC_CODE == $past(lo)) else $error("not forced to lower clamp");
    a_high_forced: assert property ($past(RST_N) && SWITCH_ACTIVE && $past(slp)
        |-> DAC_CODE == $past(hi)) else $error("not forced to upper clamp");
    a_clamp_within: assert property ($past(RST_N) && !SWITCH_ACTIVE
        && $past(lo) <= $past(hi) |-> DAC_CODE >= $past(lo) && DAC_CODE <= $past(hi))
        else $error("code outside clamps");
    a_rising_pass: assert property ($past(RST_N) && !SWITCH_ACTIVE && !$past(slp)
        && $past(RAW_CODE) >= $past(lo) && $past(RAW_CODE) <= $past(hi)
        |-> DAC_CODE == $past(RAW_CODE)) else $error("rising code altered");
    a_range_bits: assert property ($stable(sw)
        |-> RANGE_SCALE_HIGH == sw[RANGE_MSB:0]) else $error("range bits wrong");
    a_slope_view: assert property ($stable(slp)
        |-> SLOPE_FALLING == slp) else $error("slope view wrong");
    c_switch_rise: cover property (SWITCH_ACTIVE && !SLOPE_FALLING);
    c_switch_fall: cover property (SWITCH_ACTIVE && SLOPE_FALLING);
    c_read_data: cover property ($past(RD) && RDATA != 16'h0000);
endmodule : clamp_cfg_asserts

bind angle_output_clamp_config clamp_cfg_asserts i_clamp_cfg_asserts (
    .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ANGLE(ANGLE), .RAW_CODE(RAW_CODE), .DAC_CODE(DAC_CODE),
    .SWITCH_ACTIVE(SWITCH_ACTIVE), .SLOPE_FALLING(SLOPE_FALLING),
    .RANGE_SCALE_HIGH(RANGE_SCALE_HIGH), .SUPPLY_PCT(SUPPLY_PCT)
);

// ==== tb/angle_output_clamp_config_tb_top.sv ====
`timescale 1ns/1ps
module angle_output_clamp_config_tb_top
    import clamp_pkg::*;
;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic [ADDR_W-1:0] ADDR = 4'h0;
    logic [DATA_W-1:0] WDATA = 16'h0000;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [DATA_W-1:0] RDATA;
    logic [ANGLE_W-1:0] ANGLE = 16'h0000;
    logic [CODE_W-1:0] RAW_CODE = 13'h0000;
    logic [CODE_W-1:0] DAC_CODE;
    logic SWITCH_ACTIVE;
    logic SLOPE_FALLING;
    logic [RANGE_W-1:0] RANGE_SCALE_HIGH;
    logic [PCT_W-1:0] SUPPLY_PCT;
    int mismatches = 0;
    int comparisons = 0;

    angle_output_clamp_config i_angle_output_clamp_config (
        .MCLK(MCLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .ANGLE(ANGLE), .RAW_CODE(RAW_CODE), .DAC_CODE(DAC_CODE),
        .SWITCH_ACTIVE(SWITCH_ACTIVE), .SLOPE_FALLING(SLOPE_FALLING),
        .RANGE_SCALE_HIGH(RANGE_SCALE_HIGH), .SUPPLY_PCT(SUPPLY_PCT)
    );

    always #50 MCLK = ~MCLK;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge MCLK);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge MCLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge MCLK);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge MCLK);
        RD <= 1'b0;
        #1;
        chk(RDATA, exp);
    endtask : rd

    // drive the output path, then judge the code and its percent one edge later
    task automatic path(input logic [15:0] ang, input logic [12:0] raw, input int exp,
                        input logic sw_exp);
        @(posedge MCLK);
        ANGLE <= ang;
        RAW_CODE <= raw;
        @(posedge MCLK);
        #1;
        chk(16'(DAC_CODE), 16'(exp));
        chk(16'(SUPPLY_PCT), 16'(exp * 5 / 256));
        chk(16'(SWITCH_ACTIVE), 16'(sw_exp));
    endtask : path

    task automatic t_reset_values;
        rd(OFS_LOW_LIMIT, 16'h0100);
        rd(OFS_HIGH_LIMIT, 16'h12ff);
        rd(OFS_SWITCH_RANGE, 16'hffc1);
        rd(OFS_OUTPUT_CTRL, 16'h0000);
        rd(4'h5, 16'h0000);
        path(16'h0000, 13'h0000, 256, 1'b0);
    endtask : t_reset_values

    task automatic t_limits;
        wr(OFS_LOW_LIMIT, 16'h0200);
        rd(OFS_LOW_LIMIT, 16'h0200);
        wr(OFS_HIGH_LIMIT, 16'h1200);
        rd(OFS_HIGH_LIMIT, 16'h1200);
        path(16'h0000, 13'h03e8, 1000, 1'b0);
        path(16'h0000, 13'h0064, 512, 1'b0);
        path(16'h0000, 13'h01ff, 512, 1'b0);
        path(16'h0000, 13'h1200, 4608, 1'b0);
        path(16'h0000, 13'h1388, 4608, 1'b0);
    endtask : t_limits

    task automatic t_switch;
        wr(OFS_SWITCH_RANGE, 16'h8015);
        rd(OFS_SWITCH_RANGE, 16'h8015);
        chk(16'(RANGE_SCALE_HIGH), 16'h0015);
        path(16'h8000, 13'h03e8, 1000, 1'b0);
        path(16'h8001, 13'h03e8, 512, 1'b1);
        path(16'hffff, 13'h0fa0, 512, 1'b1);
    endtask : t_switch

    task automatic t_falling;
        wr(OFS_OUTPUT_CTRL, 16'h0100);
        rd(OFS_OUTPUT_CTRL, 16'h0100);
        chk(16'(SLOPE_FALLING), 16'h0001);
        path(16'h0000, 13'h03e8, 4120, 1'b0);
        path(16'h0000, 13'h012c, 4608, 1'b0);
        path(16'h0000, 13'h1450, 512, 1'b0);
        path(16'h9000, 13'h03e8, 4608, 1'b1);
        wr(OFS_OUTPUT_CTRL, 16'h0000);
        path(16'h9000, 13'h03e8, 512, 1'b1);
    endtask : t_falling

    // live code and status while the switch condition holds, then with crossed limits
    task automatic t_status;
        rd(OFS_OUTPUT_CODE, 16'h0200);
        rd(OFS_STATUS, 16'h0003);
        @(posedge MCLK);
        #1;
        chk(RDATA, 16'h0000);
        wr(OFS_LOW_LIMIT, 16'h0fa0);
        wr(OFS_HIGH_LIMIT, 16'h03e8);
        rd(OFS_STATUS, 16'h0023);
        rd(OFS_OUTPUT_CODE, 16'h0fa0);
    endtask : t_status

    task automatic report_and_stop;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (12) @(posedge MCLK);
        RST_N <= 1'b1;
        t_reset_values();
        t_limits();
        t_switch();
        t_falling();
        t_status();
        report_and_stop();
    end

    // the tests need well under a thousand cycles
    initial begin
        repeat (5000) @(posedge MCLK);
        mismatches++;
        report_and_stop();
    end
endmodule : angle_output_clamp_config_tb_top
